// ==== clock_synth_pkg.sv ====
package clock_synth_pkg;

  localparam int          NUM_REGS      = 24;
  localparam int          REG_ADDR_W    = 5;
  localparam logic [4:0]  FB_BASE       = 5'h00;
  localparam logic [4:0]  OUTDIV_BASE   = 5'h04;
  localparam logic [4:0]  CTRL_BASE     = 5'h08;
  localparam logic [4:0]  STYLE_BASE    = 5'h0c;
  localparam logic [4:0]  OE_BASE       = 5'h10;
  localparam logic [4:0]  RSVD_REG      = 5'h14;
  localparam logic [4:0]  LAST_REG      = 5'h17;

  // control register field positions
  localparam int          CP_LSB        = 0;
  localparam int          P_LSB         = 2;
  localparam int          PS_LSB        = 4;
  localparam int          BYPASS_BIT    = 6;

  // writable bit masks; other bits read zero
  localparam logic [7:0]  FB_MASK       = 8'hff;
  localparam logic [7:0]  OUTDIV_MASK   = 8'h7f;
  localparam logic [7:0]  CTRL_MASK     = 8'h7f;
  localparam logic [7:0]  OUTPUT_MASK   = 8'hee;
  localparam logic [7:0]  NO_BITS       = 8'h00;

  localparam logic [5:0]  SLAVE_ADDR_HI = 6'h37;

  localparam logic [2:0]  DIV_BY1       = 3'h1;
  localparam logic [2:0]  DIV_BY2       = 3'h2;
  localparam logic [2:0]  DIV_BY4       = 3'h4;
  localparam logic [2:0]  DIV_BY5       = 3'h5;
  localparam logic [6:0]  OUTDIV_FLOOR  = 7'h02;
  localparam logic [6:0]  OUTDIV_ODD_TOP = 7'h06;

  // synchronised pin vector positions
  localparam int          PIN_SCL       = 0;
  localparam int          PIN_SDA       = 1;
  localparam int          PIN_SEL0      = 2;
  localparam int          PIN_SEL1      = 3;
  localparam int          PIN_REFCLK    = 4;
  localparam int          PIN_ADDRSEL   = 5;
  localparam logic [5:0]  PIN_RESET     = 6'h03;

  typedef enum logic [1:0] {PRESCALE_X1, PRESCALE_HALF, PRESCALE_X2} prescale_t;

  typedef enum {I2C_IDLE, I2C_ADDR, I2C_ADDR_ACK, I2C_PTR, I2C_WDATA, I2C_DATA_ACK,
                I2C_RDATA, I2C_MASTER_ACK} i2c_state_t;

  // factory profile image, register 23 first
  localparam logic [23:0][7:0] FACTORY_DEFAULTS = {
    8'h00, 8'h00, 8'h00, 8'h00,
    8'hee, 8'hee, 8'hee, 8'hee,
    8'hee, 8'hee, 8'hee, 8'hee,
    8'h21, 8'h20, 8'h21, 8'h21,
    8'h04, 8'h08, 8'h04, 8'h08,
    8'h20, 8'h10, 8'h14, 8'h19};

endpackage

// ==== i2c_byte_slave.sv ====
`timescale 1ns/1ps
module i2c_byte_slave
  import clock_synth_pkg::*;
(
  // clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  // synchronised bus levels
  input  wire logic                  sclLevel,
  input  wire logic                  sdaLevel,
  input  wire logic [6:0]            devAddr,
  // register access
  input  wire logic [7:0]            rdByte,
  output logic      [REG_ADDR_W-1:0] regPtr,
  output logic                       wrStrobe,
  output logic      [REG_ADDR_W-1:0] wrAddr,
  output logic      [7:0]            wrData,
  output logic                       sdaOe
);
  import clock_synth_pkg::*;

  typedef struct packed {
    i2c_state_t            st;
    logic [3:0]            cnt;
    logic [7:0]            sh;
    logic                  rw;
    logic                  nack;
    logic [REG_ADDR_W-1:0] ptr;
    logic                  wr;
    logic [REG_ADDR_W-1:0] wa;
    logic [7:0]            wd;
    logic                  oe;
    logic                  sclPrev;
    logic                  sdaPrev;
  } slave_t;

  slave_t q, d;
  logic   rise, fall, startCond, stopCond;

  always_comb begin
    d         = q;
    d.wr      = 1'b0;
    d.sclPrev = sclLevel;
    d.sdaPrev = sdaLevel;
    rise      = sclLevel && !q.sclPrev;
    fall      = !sclLevel && q.sclPrev;
    startCond = sclLevel && q.sclPrev && q.sdaPrev && !sdaLevel;
    stopCond  = sclLevel && q.sclPrev && !q.sdaPrev && sdaLevel;
    if (startCond) begin
      d.st  = I2C_ADDR;
      d.cnt = '0;
      d.oe  = 1'b0;
    end else if (stopCond) begin
      d.st = I2C_IDLE;
      d.oe = 1'b0;
    end else if (rise) begin
      if (q.st == I2C_ADDR || q.st == I2C_PTR || q.st == I2C_WDATA) begin
        d.sh  = {q.sh[6:0], sdaLevel};
        d.cnt = q.cnt + 4'h1;
      end
      if (q.st == I2C_MASTER_ACK) begin
        d.nack = sdaLevel;
      end
    end else if (fall) begin
      case (q.st)
        I2C_ADDR: begin
          if (q.cnt == 4'h8) begin
            // only our address pulls the ack low
            if (q.sh[7:1] == devAddr) begin
              d.oe = 1'b1;
              d.rw = q.sh[0];
              d.st = I2C_ADDR_ACK;
            end else begin
              d.st = I2C_IDLE;
            end
          end
        end
        I2C_ADDR_ACK: begin
          d.cnt = '0;
          if (q.rw) begin
            d.sh = rdByte;
            d.oe = !rdByte[7];
            d.st = I2C_RDATA;
          end else begin
            d.oe = 1'b0;
            d.st = I2C_PTR;
          end
        end
        I2C_PTR: begin
          if (q.cnt == 4'h8) begin
            d.ptr = q.sh[REG_ADDR_W-1:0];
            d.oe  = 1'b1;
            d.st  = I2C_DATA_ACK;
          end
        end
        I2C_WDATA: begin
          if (q.cnt == 4'h8) begin
            d.wr  = 1'b1;
            d.wa  = q.ptr;
            d.wd  = q.sh;
            d.ptr = q.ptr + 5'h01;
            d.oe  = 1'b1;
            d.st  = I2C_DATA_ACK;
          end
        end
        I2C_DATA_ACK: begin
          d.oe  = 1'b0;
          d.cnt = '0;
          d.st  = I2C_WDATA;
        end
        I2C_RDATA: begin
          // msb first; release for the master's ack bit
          if (q.cnt == 4'h7) begin
            d.oe  = 1'b0;
            d.ptr = q.ptr + 5'h01;
            d.st  = I2C_MASTER_ACK;
          end else begin
            d.sh  = {q.sh[6:0], 1'b0};
            d.oe  = !q.sh[6];
            d.cnt = q.cnt + 4'h1;
          end
        end
        I2C_MASTER_ACK: begin
          d.cnt = '0;
          if (q.nack) begin
            d.st = I2C_IDLE;
          end else begin
            d.sh = rdByte;
            d.oe = !rdByte[7];
            d.st = I2C_RDATA;
          end
        end
        default: begin
          d.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q         <= '0;
      q.st      <= I2C_IDLE;
      q.sclPrev <= 1'b1;
      q.sdaPrev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign regPtr   = q.ptr;
  assign wrStrobe = q.wr;
  assign wrAddr   = q.wa;
  assign wrData   = q.wd;
  assign sdaOe    = q.oe;

  property p_ptr_advance;
    @(posedge core_clk) disable iff (!reset_n)
    q.wr |-> q.ptr == q.wa + 5'h01;
  endproperty
  a_ptr_advance: assert property (p_ptr_advance) else $error("pointer did not advance after write");

  property p_addr_ack;
    @(posedge core_clk) disable iff (!reset_n)
    (q.st == I2C_ADDR && d.st == I2C_ADDR_ACK) |-> q.sh[7:1] == devAddr;
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("acked a foreign address");

endmodule

// ==== clock_synth_profile_config.sv ====
`timescale 1ns/1ps
// Function
// - input divider codes give 1,2,4,5
// - prescaler 00 x1, 01 half, 1x x2
// - feedback divider is twice stored code
// - output divider 2..6, then even to 126
// - bandwidth field drives charge pump current
// - bypass sends prescaler through output divider
// - enable bit 1 drives, 0 high impedance
// - style bit 1 LVDS, 0 LVPECL
// - four preloaded copies of every field
// - crystal reference forces input divider one
// - selected profile applied, follows pins and writes
// - slave address 110111 plus address select
// - block access auto increments, msb first
module clock_synth_profile_config
  import clock_synth_pkg::*;
(
  // clock and reset
  input  wire logic            core_clk,
  input  wire logic            reset_n,
  // serial configuration pins
  input  wire logic            sclIn,
  input  wire logic            sdaIn,
  output logic                 sdaOut,
  output logic                 sdaOe,
  input  wire logic            addrSelect,
  // profile and reference selection
  input  wire logic [1:0]      profileSelectPins,
  input  wire logic            refSelectClk,
  // synthesizer path settings
  output logic      [2:0]      inputDivideRatio,
  output prescale_t            prescalerMode,
  output logic      [8:0]      feedbackDivideRatio,
  output logic      [6:0]      outputDivideRatio,
  output logic      [1:0]      chargePumpCurrent,
  output logic                 synthBypass,
  // output fanout settings
  output logic      [5:0]      outputDriveEnable,
  output logic      [5:0]      outputLevelStyle
);
  import clock_synth_pkg::*;

  typedef struct packed {
    logic [5:0]            syncA;
    logic [5:0]            syncB;
    logic [5:0]            syncC;
    logic [5:0]            pins;
    logic [23:0][7:0]      regs;
    logic [2:0]            inDiv;
    prescale_t             ps;
    logic [8:0]            fbDiv;
    logic [6:0]            outDiv;
    logic [1:0]            cp;
    logic                  bypass;
    logic [5:0]            drive;
    logic [5:0]            style;
  } top_t;

  top_t                  q, d;
  logic [REG_ADDR_W-1:0] regPtr;
  logic                  wrStrobe;
  logic [REG_ADDR_W-1:0] wrAddr;
  logic [7:0]            wrData;
  logic [7:0]            rdByte;
  logic [1:0]            prof;
  logic [7:0]            ctrl;

  function automatic logic [7:0] write_mask(input logic [REG_ADDR_W-1:0] a);
    if (a < OUTDIV_BASE)       write_mask = FB_MASK;
    else if (a < CTRL_BASE)    write_mask = OUTDIV_MASK;
    else if (a < STYLE_BASE)   write_mask = CTRL_MASK;
    else if (a < RSVD_REG)     write_mask = OUTPUT_MASK;
    else                       write_mask = NO_BITS;
  endfunction

  // six outputs sit around the two reserved bit positions
  function automatic logic [5:0] per_output(input logic [7:0] r);
    per_output = {r[7:5], r[3:1]};
  endfunction

  function automatic logic [6:0] out_divide(input logic [6:0] c);
    if (c < OUTDIV_FLOOR)        out_divide = OUTDIV_FLOOR;
    else if (c < OUTDIV_ODD_TOP) out_divide = c;
    else                         out_divide = {c[6:1], 1'b0};
  endfunction

  i2c_byte_slave u_slave (
    .core_clk (core_clk),
    .reset_n  (reset_n),
    .sclLevel (q.pins[PIN_SCL]),
    .sdaLevel (q.pins[PIN_SDA]),
    .devAddr  ({SLAVE_ADDR_HI, q.pins[PIN_ADDRSEL]}),
    .rdByte   (rdByte),
    .regPtr   (regPtr),
    .wrStrobe (wrStrobe),
    .wrAddr   (wrAddr),
    .wrData   (wrData),
    .sdaOe    (sdaOe)
  );

  // registers past the map read as zero
  assign rdByte = (regPtr <= LAST_REG) ? q.regs[regPtr] : 8'h00;
  assign prof   = q.pins[PIN_SEL1:PIN_SEL0];
  assign ctrl   = q.regs[CTRL_BASE + 5'(prof)];

  always_comb begin
    d       = q;
    d.syncA = {addrSelect, refSelectClk, profileSelectPins, sdaIn, sclIn};
    d.syncB = q.syncA;
    d.syncC = q.syncB;
    for (int i = 0; i < 6; i++) begin
      // a change counts only once two late stages agree
      if (q.syncB[i] == q.syncC[i]) begin
        d.pins[i] = q.syncC[i];
      end
    end
    if (wrStrobe && wrAddr <= LAST_REG) begin
      d.regs[wrAddr] = wrData & write_mask(wrAddr);
    end
    // settings recomputed every cycle from the live profile
    if (!q.pins[PIN_REFCLK]) begin
      d.inDiv = DIV_BY1;
    end else begin
      case (ctrl[P_LSB +: 2])
        2'h0:    d.inDiv = DIV_BY1;
        2'h1:    d.inDiv = DIV_BY2;
        2'h2:    d.inDiv = DIV_BY4;
        default: d.inDiv = DIV_BY5;
      endcase
    end
    case (ctrl[PS_LSB +: 2])
      2'h0:    d.ps = PRESCALE_X1;
      2'h1:    d.ps = PRESCALE_HALF;
      default: d.ps = PRESCALE_X2;
    endcase
    d.fbDiv  = {q.regs[FB_BASE + 5'(prof)], 1'b0};
    d.outDiv = out_divide(q.regs[OUTDIV_BASE + 5'(prof)][6:0]);
    d.cp     = ctrl[CP_LSB +: 2];
    d.bypass = ctrl[BYPASS_BIT];
    d.drive  = per_output(q.regs[OE_BASE + 5'(prof)]);
    d.style  = per_output(q.regs[STYLE_BASE + 5'(prof)]);
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      q        <= '0;
      q.syncA  <= PIN_RESET;
      q.syncB  <= PIN_RESET;
      q.syncC  <= PIN_RESET;
      q.pins   <= PIN_RESET;
      q.regs   <= FACTORY_DEFAULTS;
      q.inDiv  <= DIV_BY1;
      q.ps     <= PRESCALE_X1;
    end else begin
      q <= d;
    end
  end

  assign sdaOut              = 1'b0;
  assign inputDivideRatio    = q.inDiv;
  assign prescalerMode       = q.ps;
  assign feedbackDivideRatio = q.fbDiv;
  assign outputDivideRatio   = q.outDiv;
  assign chargePumpCurrent   = q.cp;
  assign synthBypass         = q.bypass;
  assign outputDriveEnable   = q.drive;
  assign outputLevelStyle    = q.style;

  property p_div5;
    @(posedge core_clk) disable iff (!reset_n)
    q.pins[PIN_REFCLK] && ctrl[P_LSB +: 2] == 2'h3 |=> inputDivideRatio == DIV_BY5;
  endproperty
  a_div5: assert property (p_div5) else $error("input divider code 11 not five");

  property p_crystal;
    @(posedge core_clk) disable iff (!reset_n)
    !q.pins[PIN_REFCLK] |=> inputDivideRatio == DIV_BY1;
  endproperty
  a_crystal: assert property (p_crystal) else $error("crystal path not divide by one");

  property p_prescale;
    @(posedge core_clk) disable iff (!reset_n)
    reset_n && ctrl[PS_LSB + 1] |=> prescalerMode == PRESCALE_X2;
  endproperty
  a_prescale: assert property (p_prescale) else $error("prescaler upper bit not x2");

  // sampled reset keeps the release edge, with outputs still cleared, out of the check
  property p_feedback;
    @(posedge core_clk) disable iff (!reset_n)
    reset_n |=> feedbackDivideRatio == {$past(q.regs[FB_BASE + 5'(prof)]), 1'b0};
  endproperty
  a_feedback: assert property (p_feedback) else $error("feedback not twice stored code");

  property p_outdiv;
    @(posedge core_clk) disable iff (!reset_n)
    q.regs[OUTDIV_BASE + 5'(prof)][6:0] == 7'h03 |=> outputDivideRatio == 7'h03;
  endproperty
  a_outdiv: assert property (p_outdiv) else $error("output divider three lost");

  property p_bypass;
    @(posedge core_clk) disable iff (!reset_n)
    reset_n |=> synthBypass == $past(ctrl[BYPASS_BIT]) && chargePumpCurrent == $past(ctrl[CP_LSB +: 2]);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass or bandwidth not followed");

  property p_drive;
    @(posedge core_clk) disable iff (!reset_n)
    reset_n |=> outputDriveEnable[0] == $past(q.regs[OE_BASE + 5'(prof)][1]);
  endproperty
  a_drive: assert property (p_drive) else $error("first output enable mismatch");

  property p_style;
    @(posedge core_clk) disable iff (!reset_n)
    reset_n |=> outputLevelStyle[5] == $past(q.regs[STYLE_BASE + 5'(prof)][7]);
  endproperty
  a_style: assert property (p_style) else $error("last output style mismatch");

  property p_readback;
    @(posedge core_clk) disable iff (!reset_n)
    wrStrobe && wrAddr <= LAST_REG |=> q.regs[$past(wrAddr)] == ($past(wrData) & write_mask($past(wrAddr)));
  endproperty
  a_readback: assert property (p_readback) else $error("written value not stored");

  property p_live_edit;
    @(posedge core_clk) disable iff (!reset_n)
    wrStrobe && wrAddr == FB_BASE + 5'(prof) && $stable(prof) ##1 $stable(prof)
      |=> feedbackDivideRatio == {$past(wrData, 2), 1'b0};
  endproperty
  a_live_edit: assert property (p_live_edit) else $error("live edit not applied in two cycles");

endmodule

// ==== i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
  // clock
  input  wire logic core_clk,
  // bus lines
  input  wire logic sdaOe,
  output logic      sclIn,
  output logic      sdaIn
);
  logic sdaDrv;

  // pull-up: low only while someone pulls it
  assign sdaIn = sdaDrv & ~sdaOe;

  initial begin
    sclIn = 1'b1;
    sdaDrv = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // 10-clock phases keep above the slave's 2-clock sampling floor
  task automatic clockBit(input logic b, output logic r);
    sclIn <= 1'b0;
    hold(5);
    sdaDrv <= b;
    hold(5);
    sclIn <= 1'b1;
    hold(10);
    r = sdaIn;
  endtask

  // also serves as repeated start
  task automatic start();
    logic r;
    hold(1);
    clockBit(1'b1, r);
    sdaDrv <= 1'b0;
    hold(10);
  endtask

  task automatic stop();
    logic r;
    clockBit(1'b0, r);
    sdaDrv <= 1'b1;
    hold(10);
  endtask

  task automatic sendByte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) clockBit(b[i], r);
    clockBit(1'b1, r);
    ack = ~r;
  endtask

  task automatic getByte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) clockBit(1'b1, d[i]);
    clockBit(last, r);
  endtask
endmodule

// ==== clock_synth_profile_config_test.sv ====
`timescale 1ns/1ps
module clock_synth_profile_config_test;
  import clock_synth_pkg::*;
  logic       core_clk, reset_n, addrSelect, refSelectClk;
  logic [1:0] profileSelectPins;
  logic       sclIn, sdaIn, sdaOut, sdaOe, ack, synthBypass;
  prescale_t  prescalerMode;
  logic [2:0] inputDivideRatio;
  logic [8:0] feedbackDivideRatio;
  logic [6:0] outputDivideRatio;
  logic [1:0] chargePumpCurrent;
  logic [5:0] outputDriveEnable, outputLevelStyle;
  logic [7:0] img [NUM_REGS];
  logic [7:0] rd;
  int         mismatches, nChecks;

  clock_synth_profile_config dut (
    .core_clk(core_clk), .reset_n(reset_n), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addrSelect(addrSelect), .profileSelectPins(profileSelectPins),
    .refSelectClk(refSelectClk), .inputDivideRatio(inputDivideRatio), .prescalerMode(prescalerMode),
    .feedbackDivideRatio(feedbackDivideRatio), .outputDivideRatio(outputDivideRatio),
    .chargePumpCurrent(chargePumpCurrent), .synthBypass(synthBypass),
    .outputDriveEnable(outputDriveEnable), .outputLevelStyle(outputLevelStyle));

  i2c_master_model master (.core_clk(core_clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", nChecks, mismatches);
    if (mismatches == 0 && nChecks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [7:0] mask(input int a);
    return a < 4 ? FB_MASK : a < 8 ? OUTDIV_MASK : a < 12 ? CTRL_MASK : a < 20 ? OUTPUT_MASK : NO_BITS;
  endfunction

  function automatic logic [5:0] outBits(input logic [7:0] b);
    return {b[7:5], b[3:1]};
  endfunction

  // expected settings worked out from the local register image
  task automatic checkOutputs();
    logic [7:0] c, n;
    c = img[CTRL_BASE + profileSelectPins];
    n = img[OUTDIV_BASE + profileSelectPins];
    chk(inputDivideRatio, !refSelectClk ? 9'h1 : c[3:2] == 2'h3 ? 9'h5 : 9'h1 << c[3:2]);
    chk(prescalerMode, c[5] ? 9'h2 : {8'h0, c[4]});
    chk(feedbackDivideRatio, {img[FB_BASE + profileSelectPins], 1'b0});
    chk(outputDivideRatio, n < 8'h2 ? 9'h2 : n < 8'h6 ? {1'b0, n} : {n[6:1], 1'b0});
    chk(chargePumpCurrent, c[1:0]);
    chk(synthBypass, c[6]);
    chk(outputDriveEnable, outBits(img[OE_BASE + profileSelectPins]));
    chk(outputLevelStyle, outBits(img[STYLE_BASE + profileSelectPins]));
  endtask

  // pins pass a 4-edge synchroniser, so 8 edges is ample
  task automatic setPins(input logic [1:0] p, input logic r);
    @(posedge core_clk);
    profileSelectPins <= p;
    refSelectClk <= r;
    repeat (8) @(posedge core_clk);
  endtask

  task automatic allProfiles();
    for (int p = 0; p < 4; p++) begin
      for (int r = 0; r < 2; r++) begin
        setPins(p[1:0], r[0]);
        checkOutputs();
      end
    end
  endtask

  task automatic writeRegs(input logic [4:0] ptr, input logic [7:0] d[$]);
    master.start();
    master.sendByte({SLAVE_ADDR_HI, addrSelect, 1'b0}, ack);
    chk(ack, 9'h1);
    master.sendByte({3'h0, ptr}, ack);
    chk(ack, 9'h1);
    foreach (d[i]) begin
      master.sendByte(d[i], ack);
      chk(ack, 9'h1);
      if (ptr + i < NUM_REGS) img[ptr + i] = d[i] & mask(ptr + i);
    end
    master.stop();
  endtask

  task automatic readRegs(input logic [4:0] ptr, input int n);
    master.start();
    master.sendByte({SLAVE_ADDR_HI, addrSelect, 1'b0}, ack);
    master.sendByte({3'h0, ptr}, ack);
    master.start();
    master.sendByte({SLAVE_ADDR_HI, addrSelect, 1'b1}, ack);
    chk(ack, 9'h1);
    for (int i = 0; i < n; i++) begin
      master.getByte(i == n - 1, rd);
      chk(rd, ptr + i < NUM_REGS ? img[ptr + i] : 8'h00);
    end
    master.stop();
  endtask

  task automatic t_defaults();
    allProfiles();
    readRegs(5'h00, NUM_REGS);
    $display("test defaults done");
  endtask

  // legal divider and bandwidth pairs, every control code used once
  task automatic t_live_write();
    setPins(2'h1, 1'b1);
    writeRegs(5'h00, '{8'h08, 8'h19, 8'h32, 8'h7d, 8'h00, 8'h03, 8'h06, 8'h7f,
                       8'h60, 8'h15, 8'h0a, 8'h7f});
    checkOutputs();
    allProfiles();
    $display("test live write done");
  endtask

  // reserved bits and the unused registers must read as zero
  task automatic t_outputs_reserved();
    writeRegs(5'h0c, '{8'hff, 8'h00, 8'h5a, 8'ha5, 8'hff, 8'h11, 8'h00, 8'hee, 8'hff});
    allProfiles();
    readRegs(5'h00, NUM_REGS);
    writeRegs(5'h18, '{8'h55});
    readRegs(5'h18, 1);
    $display("test outputs and reserved done");
  endtask

  task automatic t_foreign_addr();
    @(posedge core_clk);
    addrSelect <= 1'b1;
    repeat (8) @(posedge core_clk);
    master.start();
    master.sendByte({SLAVE_ADDR_HI, 1'b0, 1'b0}, ack);
    chk(ack, 9'h0);
    chk(sdaOut, 9'h0);
    master.stop();
    writeRegs(5'h00, '{8'h20});
    readRegs(5'h00, 2);
    checkOutputs();
    $display("test address select done");
  endtask

  initial begin
    repeat (100000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end

  initial begin
    reset_n = 1'b0;
    addrSelect = 1'b0;
    profileSelectPins = 2'h0;
    refSelectClk = 1'b1;
    mismatches = 0;
    nChecks = 0;
    foreach (img[i]) img[i] = FACTORY_DEFAULTS[i];
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    t_defaults();
    t_live_write();
    t_outputs_reserved();
    t_foreign_addr();
    give_verdict();
  end
endmodule
